// [rtl/frw_pkg.sv]
/*
  Package for the flash row write sequencer: sizes, unlock codes, reset
  values, timing constants, the FSM state type and the carrier structs.
  Assumes a single 100 MHz system clock and an asynchronous low reset.
*/
package frw_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int BLOCK_BYTES = 64;
    localparam int BLOCK_WORDS = 32;
    localparam int IDX_W = 6;
    localparam int PTR_W = 22;
    localparam int ROW_W = PTR_W - IDX_W;
    localparam logic [7:0] HOLD_RESET = 8'hFF;
    // ------------------------------------------------------------------
    // Unlock codes
    // ------------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WRITE_TIME_US = 2000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int CNT_W = 24;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FRW_IDLE = 3'h1,
        FRW_WRITE = 3'h2,
        FRW_DONE = 3'h4
    } frw_state_e;

    typedef struct packed {
        logic program_memory_select;
        logic config_space_select;
        logic write_permit;
    } frw_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [ROW_W-1:0] row;
        logic [IDX_W-1:0] index;
        logic [7:0] data;
    } frw_flash_byte_s;
endpackage

// [rtl/frw_unlock.sv]
/*
  Unlock tracker: watches writes to the unlock register and reports when
  the two codes arrived back to back in order. Any other register write
  or a start attempt clears the progress. Same clock as the core.
*/
`timescale 1ns/1ps
module frw_unlock (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic unlock_wr,
    input wire logic [7:0] unlock_data,
    input wire logic other_wr,
    input wire logic consume,
    output logic armed
);
    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    logic seen_first;
    logic next_seen_first;
    logic next_armed;

    // Any unrelated write breaks the sequence, so a stray store cannot arm
    always_comb begin
        next_seen_first = seen_first;
        next_armed = armed;
        if (consume || other_wr) begin
            next_seen_first = 1'b0;
            next_armed = 1'b0;
        end else if (unlock_wr) begin
            next_seen_first = (unlock_data == frw_pkg::UNLOCK_FIRST);
            next_armed = seen_first && (unlock_data == frw_pkg::UNLOCK_SECOND);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seen_first <= 1'b0;
            armed <= 1'b0;
        end else begin
            seen_first <= next_seen_first;
            armed <= next_armed;
        end
    end
endmodule

// [rtl/frw_sequencer.sv]
/*
  Flash row write sequencer top: 64 holding registers loaded by table
  writes, the memory control bits, the two-write unlock and the long
  write that streams the block into the flash array while the core is
  stalled. Assumes the core issues single-cycle strobes on mclk and the
  flash array accepts one byte per cycle during a long write.
*/
// Functional notes
// - Flash is programmed only as a whole 64-byte block, never one byte.
// - Sixty-four byte holding registers are filled by short table writes.
// - Setting write start begins the long write of the holding registers.
// - Instruction execution is stalled for the whole long write.
// - An on-chip timer, not software, ends the long write.
// - Holding registers read FFh after reset and after every write.
// - A holding register at FFh leaves its flash byte unchanged.
`timescale 1ns/1ps
module frw_sequencer #(
    parameter int WRITE_CYCLES = frw_pkg::WRITE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic table_write_instr,
    input wire logic [7:0] table_latch,
    input wire logic [frw_pkg::PTR_W-1:0] table_pointer_reg,
    input wire logic ctrl_wr,
    input wire frw_pkg::frw_ctrl_s ctrl_wdata,
    input wire logic start_wr,
    input wire logic unlock_wr,
    input wire logic [7:0] unlock_data,
    output frw_pkg::frw_ctrl_s memory_control_reg,
    output logic write_busy,
    output logic cpu_stall,
    output logic write_done,
    output frw_pkg::frw_flash_byte_s flash_out
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (WRITE_CYCLES < frw_pkg::BLOCK_BYTES + 1 ||
        WRITE_CYCLES >= (1 << frw_pkg::CNT_W)) begin : g_bad_time
        $error("WRITE_CYCLES out of range");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [frw_pkg::CNT_W-1:0] LAST_CNT =
        frw_pkg::CNT_W'(WRITE_CYCLES - 1);
    localparam logic [frw_pkg::CNT_W-1:0] LAST_BYTE =
        frw_pkg::CNT_W'(frw_pkg::BLOCK_BYTES - 1);

    logic [7:0] hold [frw_pkg::BLOCK_BYTES];
    logic [7:0] next_hold [frw_pkg::BLOCK_BYTES];
    frw_pkg::frw_state_e state;
    frw_pkg::frw_state_e next_state;
    logic [frw_pkg::CNT_W-1:0] cnt;
    logic [frw_pkg::CNT_W-1:0] next_cnt;
    logic [frw_pkg::ROW_W-1:0] row;
    logic [frw_pkg::ROW_W-1:0] next_row;
    frw_pkg::frw_ctrl_s next_ctrl;
    frw_pkg::frw_flash_byte_s next_flash;
    logic armed;
    logic start_ok;
    logic next_done;
    logic [frw_pkg::IDX_W-1:0] wr_idx;
    logic [frw_pkg::IDX_W-1:0] out_idx;

    // Byte index of a pointer: the low six bits
    function automatic logic [frw_pkg::IDX_W-1:0] byte_index(
        input logic [frw_pkg::PTR_W-1:0] p);
        byte_index = p[frw_pkg::IDX_W-1:0];
    endfunction

    // Block number of a pointer: everything above the byte index
    function automatic logic [frw_pkg::ROW_W-1:0] row_of(
        input logic [frw_pkg::PTR_W-1:0] p);
        row_of = p[frw_pkg::PTR_W-1:frw_pkg::IDX_W];
    endfunction

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------
    frw_unlock u_unlock (
        .mclk(mclk),
        .rst_b(rst_b),
        .unlock_wr(unlock_wr),
        .unlock_data(unlock_data),
        .other_wr(ctrl_wr | table_write_instr),
        .consume(start_wr),
        .armed(armed)
    );

    // Start needs permit plus an unlock directly before it
    assign start_ok = start_wr && armed &&
        memory_control_reg.write_permit && (state == frw_pkg::FRW_IDLE);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Kept writable during a write; the stall keeps the core away anyway
    always_comb begin
        next_ctrl = memory_control_reg;
        if (ctrl_wr) begin
            next_ctrl = ctrl_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            memory_control_reg <= '0;
        end else begin
            memory_control_reg <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------------
    assign wr_idx = byte_index(table_pointer_reg);

    generate
        for (genvar i = 0; i < frw_pkg::BLOCK_BYTES; i++) begin : g_hold
            // Short write only touches this byte; end of write refills FFh
            always_comb begin
                next_hold[i] = hold[i];
                if (state == frw_pkg::FRW_DONE) begin
                    next_hold[i] = frw_pkg::HOLD_RESET;
                end else if (table_write_instr &&
                             state == frw_pkg::FRW_IDLE &&
                             wr_idx == frw_pkg::IDX_W'(i)) begin
                    next_hold[i] = table_latch;
                end
            end

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    hold[i] <= frw_pkg::HOLD_RESET;
                end else begin
                    hold[i] <= next_hold[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Long write sequencer
    // ------------------------------------------------------------------
    // Counter runs the whole write time; the first 64 cycles stream bytes
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_row = row;
        next_done = 1'b0;
        case (state)
            frw_pkg::FRW_IDLE: begin
                next_cnt = '0;
                if (start_ok) begin
                    next_state = frw_pkg::FRW_WRITE;
                    next_row = row_of(table_pointer_reg);
                end
            end
            frw_pkg::FRW_WRITE: begin
                next_cnt = cnt + 1'b1;
                if (cnt == LAST_CNT) begin
                    next_state = frw_pkg::FRW_DONE;
                end
            end
            frw_pkg::FRW_DONE: begin
                next_state = frw_pkg::FRW_IDLE;
                next_done = 1'b1;
                next_cnt = '0;
            end
            default: begin
                next_state = frw_pkg::FRW_IDLE;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= frw_pkg::FRW_IDLE;
            cnt <= '0;
            row <= '0;
            write_done <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            row <= next_row;
            write_done <= next_done;
        end
    end

    // Stall held across write and done so the core resumes after refill
    assign write_busy = (state != frw_pkg::FRW_IDLE);
    assign cpu_stall = write_busy;

    // ------------------------------------------------------------------
    // Flash byte stream
    // ------------------------------------------------------------------
    assign out_idx = cnt[frw_pkg::IDX_W-1:0];

    // All 64 bytes go out in every write; FFh bytes are skipped as no-ops
    always_comb begin
        next_flash = '0;
        if (state == frw_pkg::FRW_WRITE && cnt <= LAST_BYTE) begin
            next_flash.row = row;
            next_flash.index = out_idx;
            next_flash.data = hold[out_idx];
            next_flash.valid = (hold[out_idx] != frw_pkg::HOLD_RESET);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flash_out <= '0;
        end else begin
            flash_out <= next_flash;
        end
    end
endmodule

// [tb/frw_sequencer_chk.sv]
/* Port checker for the flash row write sequencer.
   Sees only the top ports; one clock, asynchronous low reset. */
`timescale 1ns/1ps
module frw_sequencer_chk #(
    parameter int WRITE_CYCLES = 100
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start_wr,
    input wire frw_pkg::frw_ctrl_s memory_control_reg,
    input wire logic write_busy,
    input wire logic cpu_stall,
    input wire logic write_done,
    input wire frw_pkg::frw_flash_byte_s flash_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Busy cycles seen so far; ties every byte to its slot in the write
    int busy_cnt;
    int next_busy_cnt;
    always_comb begin
        next_busy_cnt = write_busy ? busy_cnt + 1 : 0;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 0;
        else busy_cnt <= next_busy_cnt;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_stall;
        cpu_stall == write_busy;
    endproperty
    a_stall: assert property (p_stall) else $error("stall differs");
    property p_start;
        $rose(write_busy) |-> $past(start_wr)
            && $past(memory_control_reg.write_permit);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_nopermit;
        start_wr && !write_busy
            && !memory_control_reg.write_permit |=> !write_busy;
    endproperty
    a_nopermit: assert property (p_nopermit) else $error("start taken");
    property p_len;
        $fell(write_busy) |-> busy_cnt == WRITE_CYCLES + 1 && write_done;
    endproperty
    a_len: assert property (p_len) else $error("write length");
    property p_done;
        write_done |-> $past(write_busy) ##1 !write_done;
    endproperty
    a_done: assert property (p_done) else $error("done pulse");
    property p_valid;
        flash_out.valid |-> write_busy && flash_out.data != 8'hFF;
    endproperty
    a_valid: assert property (p_valid) else $error("byte emitted");
    property p_slot;
        flash_out.valid |-> busy_cnt inside {[1:64]}
            && flash_out.index == busy_cnt[5:0] - 6'h01;
    endproperty
    a_slot: assert property (p_slot) else $error("byte slot");
    property p_hold;
        $rose(write_busy) |-> write_busy[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("stall too short");
endmodule
bind frw_sequencer frw_sequencer_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .start_wr(start_wr),
    .memory_control_reg(memory_control_reg), .write_busy(write_busy),
    .cpu_stall(cpu_stall), .write_done(write_done), .flash_out(flash_out));

// [tb/frw_core_model.sv]
/* Core model: table writes, control, unlock and start strobes.
   Assumes the sequencer samples each strobe on the rising edge. */
`timescale 1ns/1ps
module frw_core_model (
    input wire logic mclk,
    output logic tw_en,
    output logic [7:0] tlat,
    output logic [frw_pkg::PTR_W-1:0] ptr,
    output logic cw_en,
    output frw_pkg::frw_ctrl_s cdat,
    output logic sw_en,
    output logic uw_en,
    output logic [7:0] udat
);
    initial begin
        {tw_en, cw_en, sw_en, uw_en} = 4'h0;
        {tlat, udat, cdat} = '0;
        ptr = '0;
    end
    // One-cycle strobe; data inverted after so stale bytes never match
    task automatic pulse(input int k, input logic [7:0] v);
        @(negedge mclk);
        tlat = v;
        udat = v;
        case (k)
            0: tw_en = 1'b1;
            1: cw_en = 1'b1;
            2: sw_en = 1'b1;
            default: uw_en = 1'b1;
        endcase
        @(negedge mclk);
        {tw_en, cw_en, sw_en, uw_en} = 4'h0;
        tlat = ~v;
        udat = ~v;
    endtask
    task automatic set_ptr(input logic [frw_pkg::PTR_W-1:0] p);
        @(negedge mclk);
        ptr = p;
    endtask
    // Increment wraps inside the block, so start stays in range
    task automatic tw(input logic [7:0] v);
        pulse(0, v);
        ptr[5:0] = ptr[5:0] + 6'h01;
    endtask
    task automatic arm(input frw_pkg::frw_ctrl_s c);
        cdat = c;
        pulse(1, 8'h00);
    endtask
    task automatic unl(input logic [7:0] v);
        pulse(3, v);
    endtask
    task automatic go;
        pulse(2, 8'h00);
    endtask
endmodule

// [tb/frw_sequencer_bench.sv]
/* Bench for the flash row write sequencer: drives the core model and
   checks emitted flash bytes against a queue of expected notes. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module frw_sequencer_bench;
    localparam int WC = 100;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic twr, cwr, swr, uwr, busy, stall, done;
    logic [7:0] tlat, udat, d;
    logic [frw_pkg::PTR_W-1:0] ptr;
    frw_pkg::frw_ctrl_s cdat, mcr;
    frw_pkg::frw_flash_byte_s fo;
    logic [15:0] row;
    logic [29:0] exp_q[$];
    logic [29:0] exp_v;
    int bad_count = 0;
    int checked = 0;
    int seed = 32'h3034;
    frw_core_model core (.mclk(mclk), .tw_en(twr), .tlat(tlat), .ptr(ptr),
        .cw_en(cwr), .cdat(cdat), .sw_en(swr), .uw_en(uwr), .udat(udat));
    frw_sequencer #(.WRITE_CYCLES(WC)) i_dut (.mclk(mclk), .rst_b(rst_b),
        .table_write_instr(twr), .table_latch(tlat),
        .table_pointer_reg(ptr), .ctrl_wr(cwr), .ctrl_wdata(cdat),
        .start_wr(swr), .unlock_wr(uwr), .unlock_data(udat),
        .memory_control_reg(mcr), .write_busy(busy), .cpu_stall(stall),
        .write_done(done), .flash_out(fo));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // Monitor: every emitted byte must be the oldest note; sampled at the
    // falling edge so the launching edge never races the read
    always @(negedge mclk) begin
        if (fo.valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                exp_v = exp_q.pop_front();
                `CHK({fo.row, fo.index, fo.data}, exp_v)
            end
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic load(input int idx, input logic [7:0] v);
        core.set_ptr({row, idx[5:0]});
        core.tw(v);
        if (v != 8'hFF) exp_q.push_back({row, idx[5:0], v});
    endtask
    // Modes: 0 proper unlock, 1 reversed, 2 interrupted, 3 stray code
    task automatic fire(input logic pm, input int mode);
        int n;
        frw_pkg::frw_ctrl_s c;
        c = frw_pkg::frw_ctrl_s'({2'b10, pm});
        // Bad-unlock starts (modes 1 to 3) also shake the select bits, which are only stored
        if (mode != 0) c[2:1] = 2'($random(seed));
        core.arm(c);
        `CHK(mcr, c)
        if (mode == 1) begin
            core.unl(8'hAA);
            core.unl(8'h55);
        end else if (mode == 3) begin
            core.unl(8'($random(seed)) | 8'h01);
        end else begin
            core.unl(8'h55);
            if (mode == 2) core.tw(8'hFF);
            core.unl(8'hAA);
        end
        core.go();
        `CHK(stall, pm && mode == 0)
        n = 0;
        while (pm && mode == 0 && done !== 1'b1 && n < 4 * WC) begin
            @(negedge mclk);
            n++;
        end
        if (pm && mode == 0) `CHK(done, 1'b1)
        `CHK(exp_q.size(), 0)
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        row = 16'($random(seed));
        core.set_ptr({row, 6'h00});
        for (int i = 0; i < 64; i++) begin
            d = 8'($random(seed));
            core.tw(d);
            if (d != 8'hFF) exp_q.push_back({row, i[5:0], d});
        end
        fire(1'b1, 0);
        fire(1'b1, 0);
        $display("test full block done");
        row = 16'($random(seed));
        load(5, 8'hFF);
        load(9, 8'($random(seed)) & 8'hFE);
        fire(1'b1, 0);
        $display("test partial bytes done");
        for (int m = 1; m < 4; m++) fire(1'b1, m);
        fire(1'b0, 0);
        $display("test refused starts done");
        core.set_ptr({row, 6'h07});
        core.tw(8'h12);
        rst_b = 1'b0;
        @(negedge mclk);
        rst_b = 1'b1;
        fire(1'b1, 0);
        $display("test reset clears holds done");
        wrap_up;
    end
    // Watchdog sized well beyond the expected run
    initial begin
        #(100 * WC * 10);
        bad_count++;
        wrap_up;
    end
endmodule
